// File: include/mcbl_pkg.sv
// shared constants and types of the machine-check bank logger
package mcbl_pkg;
    // threads and widths
    localparam int THREADS = 4;
    localparam int TID_W = 2;
    localparam int MSR_W = 32;
    // register indices
    localparam logic [31:0] CLOAK_SMI_CONTROL_IDX = 32'h0000_0052;
    localparam logic [31:0] FETCH_BANK_ERROR_ADDRESS_IDX = 32'h0000_0412;
    localparam logic [31:0] AGENT_BANK_CONTROL_IDX = 32'h0000_0414;
    localparam logic [31:0] AGENT_BANK_ERROR_STATUS_IDX = 32'h0000_0415;
    localparam logic [31:0] AGENT_BANK_ERROR_ADDRESS_IDX = 32'h0000_0416;
    // status field positions
    localparam int LOG_VALID_BIT = 63;
    localparam int OVERFLOW_BIT = 62;
    localparam int UNCORRECTED_BIT = 61;
    localparam int ENABLED_BIT = 60;
    localparam int MISC_PRESENT_BIT = 59;
    localparam int ADDRESS_VALID_BIT = 58;
    localparam int CONTEXT_CORRUPTED_BIT = 57;
    localparam int CE_OVERFLOW_BIT = 52;
    localparam int CE_COUNT_HI = 51;
    localparam int CE_COUNT_LO = 38;
    localparam int BUFFER_RAM_BIT = 37;
    localparam int AGENT_ID_HI = 36;
    localparam int AGENT_ID_LO = 32;
    localparam int MODEL_CODE_LO = 16;
    // error codes
    localparam logic [15:0] CODE_RD_CH0 = 16'h0091;
    localparam logic [15:0] CODE_RD_CH1 = 16'h0092;
    localparam logic [15:0] CODE_WR_CH0 = 16'h00a1;
    localparam logic [15:0] CODE_WR_CH1 = 16'h00a2;
    localparam logic [15:0] CODE_BUF_RD = 16'h009f;
    localparam logic [15:0] CODE_BUF_WR = 16'h00af;
    // cloak control layout
    localparam int HIDE_CORRECTED_BIT = 0;
    localparam int PEND_IRQ_BIT = 9;
    localparam logic [63:0] CLOAK_WRITABLE = 64'h0000_0000_0000_0201;
    // reset values
    localparam logic [63:0] STATUS_RESET = 64'h0000_0000_0000_0000;
    localparam logic [63:0] ADDRESS_RESET = 64'h0000_0000_0000_0000;
    localparam logic [63:0] CONTROL_RESET = 64'h0000_0000_0000_0000;
    localparam logic [THREADS-1:0] CLOAK_RESET = 4'h0;

    typedef enum logic [1:0] {
        SRC_MEMORY = 2'h0,
        SRC_BUFFER_RAM = 2'h1,
        SRC_AGENT = 2'h2
    } mcbl_src_type;

    typedef enum logic [2:0] {
        RSP_IDLE = 3'h1,
        RSP_DONE = 3'h2,
        RSP_FAULT = 3'h4
    } mcbl_rsp_type;

    typedef struct packed {
        logic valid;
        logic write;
        logic [MSR_W-1:0] index;
        logic [63:0] data;
        logic [TID_W-1:0] thread;
        logic inSysMgmt;
    } mcbl_req_type;

    typedef struct packed {
        logic valid;
        logic corrected;
        mcbl_src_type src;
        logic isWrite;
        logic channel;
        logic corruptsContext;
        logic [4:0] agentId;
        logic [63:0] addr;
    } mcbl_err_type;
endpackage : mcbl_pkg

// File: core/mcbl_logger.sv
// machine-check bank logger of the system agent, with cloaking control
`timescale 1ns/1ps
// Notes on behaviour
// RULE1 - second error while valid sets overflow
// RULE2 - uncorrected flag set, zero when corrected
// RULE3 - status bit 60 shows reporting enabled
// RULE4 - status bit 59 always reads zero
// RULE5 - address-valid set when address captured
// RULE6 - context-corrupted set for such uncorrected errors
// RULE7 - count corrected errors in bits 51:38
// RULE8 - bit 52 marks corrected count overflow
// RULE9 - bit 37 buffer parity versus agent error
// RULE10 - requesting agent id in bits 36:32
// RULE11 - memory codes per direction and channel
// RULE12 - buffer RAM codes 009F read, 00AF write
// RULE13 - address register holds faulting physical address
// RULE14 - status cleared by zeros, survives warm reset
// RULE15 - cloak control only in system management mode
// RULE16 - one cloak control per thread
// RULE17 - cloak reserved bits zero, write faults
// RULE18 - hide corrected status outside system management
// RULE19 - pend interrupt on uncorrected, context intact
// RULE20 - control bits act at once
// RULE21 - error outputs go to cores and board
// RULE22 - machine check on parity, ECC, completion
// RULE23 - board ignores outputs until platform reset released
// RULE24 - status and address captured together
module mcbl_logger (
    // clock and resets
    input wire logic mclk,
    input wire logic rst,
    input wire logic warmRst,
    // register access from the executing thread
    input wire mcbl_pkg::mcbl_req_type msrReq,
    output logic msrRspValid,
    output logic msrRspFault,
    output logic [63:0] msrRspData,
    // error sources
    input wire mcbl_pkg::mcbl_err_type errEvent,
    input wire logic unexpectedCompletion,
    input wire logic internalErrorEvent,
    input wire logic [63:0] fetchBankAddr,
    // interrupt handshake per thread
    input wire logic [mcbl_pkg::THREADS-1:0] irqAck,
    output logic [mcbl_pkg::THREADS-1:0] sysMgmtIrqPending,
    // error signalling to cores and board
    output logic machineCheckCoreOutN,
    output logic machineCheckBoardOutN,
    output logic internalErrorCoreOutN,
    output logic internalErrorBoardOutN
);
    typedef struct packed {
        logic [63:0] status;
        logic [63:0] addr;
        logic [63:0] control;
        logic [mcbl_pkg::THREADS-1:0] hideCorrected;
        logic [mcbl_pkg::THREADS-1:0] pendIrq;
        logic [mcbl_pkg::THREADS-1:0] irqPend;
        logic mcN;
        logic ierrN;
        mcbl_pkg::mcbl_rsp_type rsp;
        logic rspValid;
        logic rspFault;
        logic [63:0] rspData;
    } mcbl_state_type;

    mcbl_state_type state_reg;
    mcbl_state_type state_next;

    logic [15:0] errCode;
    logic [63:0] statusView;
    logic [13:0] ceCount;
    logic [14:0] ceSum;
    logic curValid;
    logic curUnc;
    logic newUnc;
    logic takeLog;
    logic rdFault;
    logic wrFault;
    logic isCloak;
    logic [mcbl_pkg::TID_W-1:0] tid;

    // error code from source, direction and channel
    always_comb begin
        errCode = mcbl_pkg::CODE_BUF_RD;
        case (errEvent.src)
            mcbl_pkg::SRC_MEMORY: begin
                if (errEvent.isWrite) begin
                    errCode = errEvent.channel ? mcbl_pkg::CODE_WR_CH1
                                               : mcbl_pkg::CODE_WR_CH0; // RULE11
                end else begin
                    errCode = errEvent.channel ? mcbl_pkg::CODE_RD_CH1
                                               : mcbl_pkg::CODE_RD_CH0; // RULE11
                end
            end
            mcbl_pkg::SRC_BUFFER_RAM, mcbl_pkg::SRC_AGENT: begin
                errCode = errEvent.isWrite ? mcbl_pkg::CODE_BUF_WR
                                           : mcbl_pkg::CODE_BUF_RD; // RULE12
            end
            default: begin
                errCode = mcbl_pkg::CODE_BUF_RD;
            end
        endcase
    end

    // read view of status with cloaking of corrected errors
    always_comb begin
        tid = msrReq.thread;
        statusView = state_reg.status;
        statusView[mcbl_pkg::MISC_PRESENT_BIT] = 1'b0; // RULE4
        statusView[mcbl_pkg::ENABLED_BIT] = |state_reg.control; // RULE3
        if (state_reg.hideCorrected[tid] && !msrReq.inSysMgmt
                && state_reg.status[mcbl_pkg::LOG_VALID_BIT]
                && !state_reg.status[mcbl_pkg::UNCORRECTED_BIT]
                && !state_reg.status[mcbl_pkg::CONTEXT_CORRUPTED_BIT]) begin
            statusView = 64'h0000_0000_0000_0000; // RULE18 RULE20
        end
    end

    always_comb begin
        state_next = state_reg;
        state_next.rsp = mcbl_pkg::RSP_IDLE;
        isCloak = (msrReq.index == mcbl_pkg::CLOAK_SMI_CONTROL_IDX);
        rdFault = 1'b0;
        wrFault = 1'b0;
        curValid = 1'b0;
        curUnc = 1'b0;
        newUnc = 1'b0;
        takeLog = 1'b0;
        ceCount = 14'h0000;
        ceSum = 15'h0000;

        // register access; replies one cycle later, lost in warm reset
        if (msrReq.valid && !warmRst) begin
            state_next.rspData = 64'h0000_0000_0000_0000;
            if (isCloak && !msrReq.inSysMgmt) begin
                rdFault = 1'b1; // RULE15
            end else if (msrReq.write) begin
                case (msrReq.index)
                    mcbl_pkg::CLOAK_SMI_CONTROL_IDX: begin
                        if (|(msrReq.data & ~mcbl_pkg::CLOAK_WRITABLE)) begin
                            wrFault = 1'b1; // RULE17
                        end else begin
                            state_next.hideCorrected[tid] =
                                msrReq.data[mcbl_pkg::HIDE_CORRECTED_BIT]; // RULE16
                            state_next.pendIrq[tid] =
                                msrReq.data[mcbl_pkg::PEND_IRQ_BIT]; // RULE16
                        end
                    end
                    mcbl_pkg::AGENT_BANK_CONTROL_IDX: begin
                        state_next.control = msrReq.data;
                    end
                    mcbl_pkg::AGENT_BANK_ERROR_STATUS_IDX: begin
                        if (|msrReq.data) begin
                            wrFault = 1'b1;
                        end else begin
                            state_next.status = mcbl_pkg::STATUS_RESET; // RULE14
                            state_next.mcN = 1'b1;
                        end
                    end
                    default: begin
                        wrFault = 1'b1;
                    end
                endcase
            end else begin
                case (msrReq.index)
                    mcbl_pkg::CLOAK_SMI_CONTROL_IDX: begin
                        state_next.rspData[mcbl_pkg::HIDE_CORRECTED_BIT] =
                            state_reg.hideCorrected[tid]; // RULE17
                        state_next.rspData[mcbl_pkg::PEND_IRQ_BIT] =
                            state_reg.pendIrq[tid]; // RULE17
                    end
                    mcbl_pkg::FETCH_BANK_ERROR_ADDRESS_IDX: begin
                        state_next.rspData = fetchBankAddr;
                    end
                    mcbl_pkg::AGENT_BANK_CONTROL_IDX: begin
                        state_next.rspData = state_reg.control;
                    end
                    mcbl_pkg::AGENT_BANK_ERROR_STATUS_IDX: begin
                        state_next.rspData = statusView;
                    end
                    mcbl_pkg::AGENT_BANK_ERROR_ADDRESS_IDX: begin
                        state_next.rspData = state_reg.addr;
                    end
                    default: begin
                        rdFault = 1'b1;
                    end
                endcase
            end
            state_next.rsp = (rdFault || wrFault) ? mcbl_pkg::RSP_FAULT
                                                  : mcbl_pkg::RSP_DONE;
            if (rdFault || wrFault) begin
                state_next.rspData = 64'h0000_0000_0000_0000;
            end
        end

        // error logging; an event in the clearing cycle lands on the
        // cleared log so it is never lost
        if (errEvent.valid) begin
            curValid = state_next.status[mcbl_pkg::LOG_VALID_BIT];
            curUnc = state_next.status[mcbl_pkg::UNCORRECTED_BIT];
            newUnc = !errEvent.corrected;
            takeLog = !curValid || (newUnc && !curUnc);
            if (curValid) begin
                state_next.status[mcbl_pkg::OVERFLOW_BIT] = 1'b1; // RULE1
            end
            if (errEvent.corrected) begin
                ceCount = state_next.status[mcbl_pkg::CE_COUNT_HI:
                                            mcbl_pkg::CE_COUNT_LO];
                ceSum = {1'b0, ceCount} + 15'h0001;
                state_next.status[mcbl_pkg::CE_COUNT_HI:
                                  mcbl_pkg::CE_COUNT_LO] = ceSum[13:0]; // RULE7
                if (ceSum[14]) begin
                    state_next.status[mcbl_pkg::CE_OVERFLOW_BIT] = 1'b1; // RULE8
                end
            end
            if (takeLog) begin
                state_next.status[mcbl_pkg::LOG_VALID_BIT] = 1'b1;
                state_next.status[mcbl_pkg::UNCORRECTED_BIT] = newUnc; // RULE2
                state_next.status[mcbl_pkg::CONTEXT_CORRUPTED_BIT] =
                    newUnc && errEvent.corruptsContext; // RULE6
                state_next.status[mcbl_pkg::ADDRESS_VALID_BIT] = 1'b1; // RULE5
                state_next.status[mcbl_pkg::BUFFER_RAM_BIT] =
                    (errEvent.src == mcbl_pkg::SRC_BUFFER_RAM); // RULE9
                state_next.status[mcbl_pkg::AGENT_ID_HI:
                                  mcbl_pkg::AGENT_ID_LO] =
                    (errEvent.src == mcbl_pkg::SRC_AGENT) ? errEvent.agentId
                                                          : 5'h00; // RULE10
                state_next.status[31:mcbl_pkg::MODEL_CODE_LO] = errCode; // RULE11
                state_next.status[15:0] = errCode; // RULE12
                state_next.addr = errEvent.addr; // RULE13 RULE24
            end
            if (newUnc && !errEvent.corruptsContext) begin
                state_next.irqPend = state_next.irqPend
                                     | state_reg.pendIrq; // RULE19 RULE20
            end
            if (newUnc && (|state_reg.control)) begin
                state_next.mcN = 1'b0; // RULE22
            end
        end
        if (unexpectedCompletion && (|state_reg.control)) begin
            state_next.mcN = 1'b0; // RULE22
        end
        if (internalErrorEvent) begin
            state_next.ierrN = 1'b0;
        end

        // acknowledge clears, a new pend in the same cycle wins
        for (int t = 0; t < mcbl_pkg::THREADS; t++) begin
            if (irqAck[t] && !(errEvent.valid && newUnc
                    && !errEvent.corruptsContext && state_reg.pendIrq[t])) begin
                state_next.irqPend[t] = 1'b0;
            end
        end

        // warm reset keeps the error log and bank control
        if (warmRst) begin
            state_next.hideCorrected = mcbl_pkg::CLOAK_RESET; // RULE17
            state_next.pendIrq = mcbl_pkg::CLOAK_RESET; // RULE17
            state_next.irqPend = '0;
            state_next.mcN = 1'b1;
            state_next.ierrN = 1'b1;
            state_next.rsp = mcbl_pkg::RSP_IDLE;
            state_next.rspData = 64'h0000_0000_0000_0000;
        end
        state_next.rspValid = (state_next.rsp != mcbl_pkg::RSP_IDLE);
        state_next.rspFault = (state_next.rsp == mcbl_pkg::RSP_FAULT);
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_reg.status <= mcbl_pkg::STATUS_RESET;
            state_reg.addr <= mcbl_pkg::ADDRESS_RESET;
            state_reg.control <= mcbl_pkg::CONTROL_RESET;
            state_reg.hideCorrected <= mcbl_pkg::CLOAK_RESET;
            state_reg.pendIrq <= mcbl_pkg::CLOAK_RESET;
            state_reg.irqPend <= '0;
            state_reg.mcN <= 1'b1;
            state_reg.ierrN <= 1'b1;
            state_reg.rsp <= mcbl_pkg::RSP_IDLE;
            state_reg.rspValid <= 1'b0;
            state_reg.rspFault <= 1'b0;
            state_reg.rspData <= 64'h0000_0000_0000_0000;
        end else begin
            state_reg <= state_next; // RULE14
        end
    end

    // outputs straight from the state flops
    assign msrRspValid = state_reg.rspValid;
    assign msrRspFault = state_reg.rspFault;
    assign msrRspData = state_reg.rspData;
    assign sysMgmtIrqPending = state_reg.irqPend;
    assign machineCheckCoreOutN = state_reg.mcN; // RULE21
    assign machineCheckBoardOutN = state_reg.mcN; // RULE21
    assign internalErrorCoreOutN = state_reg.ierrN; // RULE21
    assign internalErrorBoardOutN = state_reg.ierrN; // RULE21
endmodule : mcbl_logger

// File: testbench/mcbl_logger_properties.sv
// assertions on the ports of the machine-check bank logger
`timescale 1ns/1ps
module mcbl_logger_checker (
    // clock and resets
    input wire logic mclk,
    input wire logic rst,
    input wire logic warmRst,
    // register access
    input wire mcbl_pkg::mcbl_req_type msrReq,
    input wire logic msrRspFault,
    input wire logic msrRspValid,
    input wire logic [63:0] msrRspData,
    // errors and signalling
    input wire mcbl_pkg::mcbl_err_type errEvent,
    input wire logic unexpectedCompletion,
    input wire logic internalErrorEvent,
    input wire logic [mcbl_pkg::THREADS-1:0] sysMgmtIrqPending,
    input wire logic machineCheckCoreOutN,
    input wire logic machineCheckBoardOutN,
    input wire logic internalErrorCoreOutN,
    input wire logic internalErrorBoardOutN
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst || warmRst);
    logic cl, st;
    assign cl = msrReq.valid && msrReq.index == 32'h0000_0052;
    assign st = msrReq.valid && msrReq.index == 32'h0000_0415;
    a_rsp_next_cycle: assert property (
        msrReq.valid |=> msrRspValid) else $error("reply missing");
    a_cloak_gp_fault: assert property (
        cl && !msrReq.inSysMgmt |=> msrRspFault && msrRspData == 64'h0)
        else $error("cloak access outside mode not refused");
    a_resv_write_fault: assert property (
        cl && msrReq.write
        && (msrReq.data & ~mcbl_pkg::CLOAK_WRITABLE) != 64'h0
        |=> msrRspFault) else $error("reserved cloak write accepted");
    a_misc_bit_zero: assert property (
        st && !msrReq.write |=> !msrRspData[59])
        else $error("status bit 59 set");
    a_pins_paired: assert property (
        machineCheckCoreOutN == machineCheckBoardOutN
        && internalErrorCoreOutN == internalErrorBoardOutN)
        else $error("core and board pins differ");
    a_ierr_raise: assert property (
        internalErrorEvent |=> !internalErrorCoreOutN [*4])
        else $error("internal error pin not held low");
    a_mc_cause: assert property (
        $fell(machineCheckCoreOutN)
        |-> $past(errEvent.valid || unexpectedCompletion))
        else $error("machine check without cause");
    a_mc_held: assert property (
        !machineCheckCoreOutN && !(st && msrReq.write)
        |=> !machineCheckCoreOutN) else $error("machine check dropped");
    a_irq_cause: assert property (
        $rose(sysMgmtIrqPending[0]) |-> $past(errEvent.valid
        && !errEvent.corrected && !errEvent.corruptsContext))
        else $error("interrupt pended without cause");
endmodule : mcbl_logger_checker

// File: testbench/mcbl_board_model.sv
// board controller model: watches error pins, acks interrupts
`timescale 1ns/1ps
module mcbl_board_model (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // control and observation
    input wire logic ackEn,
    input wire logic mcN,
    input wire logic ierrN,
    input wire logic [3:0] pend,
    output logic [3:0] irqAck,
    output logic mcSeen
);
    always_ff @(posedge mclk) begin
        if (rst) begin
            irqAck <= 4'h0;
            mcSeen <= 1'b0;
        end else begin
            irqAck <= ackEn ? (pend & ~irqAck) : 4'h0;
            mcSeen <= mcSeen | !mcN | !ierrN;
        end
    end
endmodule : mcbl_board_model

// File: testbench/test_mcbl_logger.sv
// self-checking bench of the machine-check bank logger
`timescale 1ns/1ps
module test_mcbl_logger;
    localparam logic [31:0] CL = 32'h0000_0052;
    localparam logic [31:0] CT = 32'h0000_0414;
    localparam logic [31:0] ST = 32'h0000_0415;
    localparam logic [31:0] AD = 32'h0000_0416;
    localparam logic [63:0] FA = 64'h0000_00ab_cdef_0040;
    localparam logic [63:0] OV = 64'h4000_0000_0000_0000;
    logic mclk, rst, warmRst, ackEn, mcSeen, unexp, ierrEv;
    logic rspV, rspF, mcN, mcBN, ieN, ieBN;
    logic [63:0] rspD, rd;
    logic [3:0] irqAck, pend;
    logic [15:0] codes [4];
    mcbl_pkg::mcbl_req_type req;
    mcbl_pkg::mcbl_err_type ev;
    int num_errors, checks_done;
    mcbl_logger dut (.mclk(mclk), .rst(rst), .warmRst(warmRst),
        .msrReq(req), .msrRspValid(rspV), .msrRspFault(rspF),
        .msrRspData(rspD), .errEvent(ev), .unexpectedCompletion(unexp),
        .internalErrorEvent(ierrEv), .fetchBankAddr(FA),
        .irqAck(irqAck), .sysMgmtIrqPending(pend),
        .machineCheckCoreOutN(mcN), .machineCheckBoardOutN(mcBN),
        .internalErrorCoreOutN(ieN), .internalErrorBoardOutN(ieBN));
    mcbl_board_model board (.mclk(mclk), .rst(rst), .ackEn(ackEn),
        .mcN(mcBN), .ierrN(ieBN), .pend(pend), .irqAck(irqAck),
        .mcSeen(mcSeen));
    task automatic chk(string n, logic [63:0] seen, logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk
    task automatic msr(logic w, logic [31:0] i, logic [63:0] d,
        logic [1:0] t, logic system_management_mode, logic f);
        @(posedge mclk) #1;
        req = '{1'b1, w, i, d, t, system_management_mode};
        @(posedge mclk) #1;
        req.valid = 1'b0;
        chk("reply", rspV, 1);
        chk("fault", rspF, f);
        rd = rspD;
    endtask : msr
    task automatic rdc(string n, logic [31:0] i, logic [1:0] t,
        logic system_management_mode, logic [63:0] e);
        msr(0, i, 0, t, system_management_mode, 0);
        chk(n, rd, e);
    endtask : rdc
    task automatic err(logic c, logic [1:0] s, logic w, logic ch,
        logic p, logic [4:0] id, logic [63:0] a);
        @(posedge mclk) #1;
        ev = '{1'b1, c, mcbl_pkg::mcbl_src_type'(s), w, ch, p, id, a};
        @(posedge mclk) #1;
        ev.valid = 1'b0;
    endtask : err
    function automatic logic [63:0] sw(logic uc, logic context_corrupted_flag, logic b,
        logic [4:0] id, logic [15:0] c, logic [13:0] n);
        sw = {4'hb ^ {2'b0, !uc, 1'b0}, 3'h2 | {2'b0, context_corrupted_flag}, 5'h0, n,
            b, id, c, c};
    endfunction : sw
    task automatic tally_and_finish();
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : tally_and_finish
    initial begin
        mclk = 0;
        forever #4 mclk = ~mclk;
    end
    initial begin
        #480000;
        num_errors++;
        tally_and_finish();
    end
    initial begin
        {rst, warmRst, ackEn, unexp, ierrEv} = 5'h10;
        req = '0;
        ev = '0;
        num_errors = 0;
        checks_done = 0;
        codes = '{16'h0091, 16'h0092, 16'h00a1, 16'h00a2};
        repeat (6) @(posedge mclk);
        #1 rst = 0;
        rdc("cloak reset", CL, 0, 1, 0);
        msr(0, CL, 0, 0, 0, 1);
        msr(1, CL, 64'h0000_0000_0000_0002, 0, 1, 1);
        msr(1, CL, 64'h0000_0000_0000_0201, 0, 1, 0);
        rdc("cloak t0", CL, 0, 1, 64'h0000_0000_0000_0201);
        rdc("cloak t1", CL, 1, 1, 0);
        msr(0, 32'h0000_0417, 0, 2, 0, 1);
        msr(1, CT, 1, 2, 0, 0);
        rdc("ctl", CT, 2, 0, 1);
        rdc("fetch", 32'h0000_0412, 2, 0, FA);
        for (int i = 0; i < 4; i++) begin
            msr(1, ST, 0, 2, 0, 0);
            err(1, 0, i[1], i[0], 0, 0, FA + i);
            rdc("mem", ST, 2, 0, sw(0, 0, 0, 0, codes[i], 1));
            rdc("addr", AD, 2, 0, FA + i);
        end
        rdc("hidden", ST, 0, 0, 0);
        rdc("smm view", ST, 0, 1, sw(0, 0, 0, 0, codes[3], 1));
        err(1, 0, 1, 1, 0, 0, FA);
        rdc("over", ST, 2, 0, sw(0, 0, 0, 0, codes[3], 2) | OV);
        msr(1, CL, 64'h0000_0000_0000_0200, 0, 1, 0);
        rdc("shown", ST, 0, 0, sw(0, 0, 0, 0, codes[3], 2) | OV);
        msr(1, ST, 0, 2, 0, 0);
        err(0, 1, 0, 0, 0, 0, FA);
        rdc("buf", ST, 2, 0, sw(1, 0, 1, 0, 16'h009f, 0));
        chk("pend", pend, 4'h1);
        chk("mc low", mcN, 0);
        ackEn = 1;
        repeat (3) @(posedge mclk);
        #1 ackEn = 0;
        chk("acked", pend, 0);
        chk("board saw", mcSeen, 1);
        msr(1, ST, 0, 2, 0, 0);
        chk("mc free", mcN, 1);
        err(0, 2, 1, 0, 1, 5'h15, FA);
        rdc("agent", ST, 2, 0, sw(1, 1, 0, 5'h15, 16'h00af, 0));
        chk("no pend", pend, 0);
        @(posedge mclk) #1 ierrEv = 1;
        @(posedge mclk) #1 ierrEv = 0;
        chk("ierr", {ieN, ieBN}, 0);
        @(posedge mclk) #1 warmRst = 1;
        @(posedge mclk) #1 warmRst = 0;
        chk("ierr free", ieN, 1);
        rdc("kept", ST, 2, 0, sw(1, 1, 0, 5'h15, 16'h00af, 0));
        rdc("cloak warm", CL, 0, 1, 0);
        msr(1, ST, 1, 2, 0, 1);
        msr(1, ST, 0, 2, 0, 0);
        @(posedge mclk) #1 unexp = 1;
        @(posedge mclk) #1 unexp = 0;
        chk("completion", mcN, 0);
        msr(1, ST, 0, 2, 0, 0);
        ev = '{1'b1, 1'b1, mcbl_pkg::SRC_MEMORY, 1'b0, 1'b0, 1'b0, 5'h0, FA};
        repeat (16384) @(posedge mclk);
        #1 ev.valid = 0;
        rdc("count", ST, 2, 0, sw(0, 0, 0, 0, codes[0], 0) | OV
            | 64'h0010_0000_0000_0000);
        msr(1, CT, 0, 2, 0, 0);
        rdc("en off", ST, 2, 0, sw(0, 0, 0, 0, codes[0], 0)
            ^ 64'h5010_0000_0000_0000);
        tally_and_finish();
    end
endmodule : test_mcbl_logger
bind mcbl_logger mcbl_logger_checker props (.mclk, .rst, .warmRst,
    .msrReq, .msrRspFault, .msrRspValid, .msrRspData, .errEvent,
    .unexpectedCompletion, .internalErrorEvent, .sysMgmtIrqPending,
    .machineCheckCoreOutN, .machineCheckBoardOutN,
    .internalErrorCoreOutN, .internalErrorBoardOutN);
